// ===== logic/cifl_defs.vh
// Offsets, field positions and the control reset value of the interrupt flag block
`ifndef CIFL_DEFS_VH
`define CIFL_DEFS_VH
`define CIFL_OFF_CTRL        12'h000
`define CIFL_OFF_PERIPH      12'h004
`define CIFL_OFF_PORT_B      12'h008
`define CIFL_OFF_IRQ_STAT    12'h00C
`define CIFL_OFF_IRQ_MASK    12'h010
`define CIFL_BIT_GLOBAL_EN   7
`define CIFL_BIT_GROUP_EN    6
`define CIFL_BIT_OVF_EN      5
`define CIFL_BIT_PIN_EN      4
`define CIFL_BIT_CHG_EN      3
`define CIFL_BIT_OVF_FLAG    2
`define CIFL_BIT_PIN_FLAG    1
`define CIFL_BIT_CHG_FLAG    0
`define CIFL_CTRL_RESET      8'h00
`define CIFL_PERIPH_W        8
`define CIFL_STAT_W          3
`define CIFL_ST_OVF          0
`define CIFL_ST_PIN          1
`define CIFL_ST_CHG          2
`endif

// ===== logic/cifl_sync.v
// Two flip-flop synchroniser for a bank of pin inputs
`timescale 1ns/1ps
module cifl_sync #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input  wire             clk,
  input  wire             rst,
  input  wire             ce,
  // Data
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_q;

  always @(posedge clk)
  begin
    if (rst)
    begin
      meta_q   <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end
    else if (ce)
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // cifl_sync

// ===== logic/cifl_core_irq.v
// Core interrupt control and flag register with APB access
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps
`include "cifl_defs.vh"
module cifl_core_irq #(
  parameter PORT_B_W = 4
) (
  // Clock, reset, enable
  input  wire                      clk,
  input  wire                      rst,
  input  wire                      ce,
  // APB slave
  input  wire                      psel,
  input  wire                      penable,
  input  wire                      pwrite,
  input  wire [11:0]               paddr,
  input  wire [31:0]               pwdata,
  output wire [31:0]               prdata,
  output wire                      pready,
  output wire                      pslverr,
  // Event sources
  input  wire                      timer_zero_overflow,
  input  wire                      external_interrupt_pin,
  input  wire                      ext_edge_rising,
  input  wire [PORT_B_W-1:0]       port_b_pins,
  input  wire [`CIFL_PERIPH_W-1:0] periph_irq_pending,
  // Core request and block interrupt
  output wire                      core_irq_req,
  output wire                      irq
);
  reg  [7:0]          ctrl_q;
  reg  [PORT_B_W-1:0] port_b_latch_q;
  reg                 ext_prev_q;
  reg  [2:0]          stat_q;
  reg  [2:0]          mask_q;
  reg  [31:0]         prdata_q;
  reg  [31:0]         prdata_d;
  wire [PORT_B_W-1:0] port_b_s;
  wire                ext_s;
  wire                wr_en;
  wire                rd_en;
  wire                setup_rd;
  wire                wr_ctrl;
  wire                wr_stat;
  wire                wr_mask;
  wire                rd_port_b;
  wire                ext_rise;
  wire                ext_fall;
  wire                ext_edge;
  wire                rb_mismatch;
  wire                periph_req;
  wire                ovf_req;
  wire                pin_req;
  wire                chg_req;
  wire [2:0]          ev;
  wire [2:0]          ctrl_set;

  // Address compare
  function hit;
    input [11:0] a;
    input [11:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  function mapped;
    input [11:0] a;
    begin
      mapped = hit(a, `CIFL_OFF_CTRL) | hit(a, `CIFL_OFF_PERIPH) |
               hit(a, `CIFL_OFF_PORT_B) | hit(a, `CIFL_OFF_IRQ_STAT) |
               hit(a, `CIFL_OFF_IRQ_MASK);
    end
  endfunction

  // Pin synchronisers
  cifl_sync #(
    .WIDTH (PORT_B_W + 1)
  ) u_sync (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .async_in ({external_interrupt_pin, port_b_pins}),
    .sync_out ({ext_s, port_b_s})
  );

  // Bus qualifiers
  assign wr_en     = psel & penable & pwrite & ce;
  assign rd_en     = psel & penable & ~pwrite & ce;
  assign setup_rd  = psel & ~penable & ~pwrite & ce;
  assign wr_ctrl   = wr_en & hit(paddr, `CIFL_OFF_CTRL);
  assign wr_stat   = wr_en & hit(paddr, `CIFL_OFF_IRQ_STAT);
  assign wr_mask   = wr_en & hit(paddr, `CIFL_OFF_IRQ_MASK);
  assign rd_port_b = rd_en & hit(paddr, `CIFL_OFF_PORT_B);

  // Bus responses
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped(paddr);
  assign prdata  = prdata_q;

  // Edge detection on the external pin
  assign ext_rise = ext_s & ~ext_prev_q;
  assign ext_fall = ~ext_s & ext_prev_q;
  assign ext_edge = ext_edge_rising ? ext_rise : ext_fall;

  // Mismatch against last port B read
  assign rb_mismatch = (port_b_s != port_b_latch_q);

  assign ev = {rb_mismatch, ext_edge, timer_zero_overflow};

  // Flag set terms, independent of any enable
  assign ctrl_set = {timer_zero_overflow, ext_edge, rb_mismatch};

  always @(posedge clk)
  begin
    if (rst)
    begin
      ctrl_q <= `CIFL_CTRL_RESET;
    end
    else if (ce)
    begin
      if (wr_ctrl)
      begin
        ctrl_q <= pwdata[7:0];
      end
      // Set wins over a software clear in the same cycle
      if (ctrl_set[2])
      begin
        ctrl_q[`CIFL_BIT_OVF_FLAG] <= 1'b1;
      end
      if (ctrl_set[1])
      begin
        ctrl_q[`CIFL_BIT_PIN_FLAG] <= 1'b1;
      end
      if (ctrl_set[0])
      begin
        ctrl_q[`CIFL_BIT_CHG_FLAG] <= 1'b1;
      end
    end
  end

  // Previous synchronised pin level
  always @(posedge clk)
  begin
    if (rst)
    begin
      ext_prev_q <= 1'b0;
    end
    else if (ce)
    begin
      ext_prev_q <= ext_s;
    end
  end

  // Port B read refreshes the mismatch latch
  always @(posedge clk)
  begin
    if (rst)
    begin
      port_b_latch_q <= {PORT_B_W{1'b0}};
    end
    else if (ce)
    begin
      if (rd_port_b)
      begin
        port_b_latch_q <= port_b_s;
      end
    end
  end

  // Sticky event status, write one to clear
  genvar gi;
  generate
    for (gi = 0; gi < `CIFL_STAT_W; gi = gi + 1)
    begin : g_stat
      always @(posedge clk)
      begin
        if (rst)
          stat_q[gi] <= 1'b0;
        else if (ce)
        begin
          if (ev[gi])
          begin
            stat_q[gi] <= 1'b1;
          end
          else if (wr_stat && pwdata[gi])
          begin
            stat_q[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Event mask register
  always @(posedge clk)
  begin
    if (rst)
    begin
      mask_q <= 3'h0;
    end
    else if (ce)
    begin
      if (wr_mask)
      begin
        mask_q <= pwdata[2:0];
      end
    end
  end

  // Read data selection
  always @*
  begin
    prdata_d = 32'h00000000;
    case (paddr)
      `CIFL_OFF_CTRL:
      begin
        prdata_d = {24'h000000, ctrl_q};
      end
      `CIFL_OFF_PERIPH:
      begin
        prdata_d = {24'h000000, periph_irq_pending};
      end
      `CIFL_OFF_PORT_B:
      begin
        prdata_d = {{(32-PORT_B_W){1'b0}}, port_b_s};
      end
      `CIFL_OFF_IRQ_STAT:
      begin
        prdata_d = {29'h00000000, stat_q};
      end
      `CIFL_OFF_IRQ_MASK:
      begin
        prdata_d = {29'h00000000, mask_q};
      end
      default:
      begin
        prdata_d = 32'h00000000;
      end
    endcase
  end

  // Read data register, loaded in the setup cycle
  always @(posedge clk)
  begin
    if (rst)
    begin
      prdata_q <= 32'h00000000;
    end
    else if (setup_rd)
    begin
      prdata_q <= prdata_d;
    end
  end

  // Per-source request terms
  assign ovf_req = ctrl_q[`CIFL_BIT_OVF_EN] & ctrl_q[`CIFL_BIT_OVF_FLAG];
  assign pin_req = ctrl_q[`CIFL_BIT_PIN_EN] & ctrl_q[`CIFL_BIT_PIN_FLAG];
  assign chg_req = ctrl_q[`CIFL_BIT_CHG_EN] & ctrl_q[`CIFL_BIT_CHG_FLAG];

  // Peripheral group gate
  assign periph_req = ctrl_q[`CIFL_BIT_GROUP_EN] & (|periph_irq_pending);

  // Core request under the global enable
  assign core_irq_req = ctrl_q[`CIFL_BIT_GLOBAL_EN] &
    (ovf_req | pin_req | chg_req | periph_req);

  // Block interrupt from masked sticky status
  assign irq = |(stat_q & mask_q);
endmodule // cifl_core_irq

// ===== testbench/cifl_src.sv
// Event source model driving the timer and pin inputs
`timescale 1ns/1ps
module cifl_src (
  // Clock and commands
  input  wire logic clk,
  input  wire logic tick,
  input  wire logic flip,
  // Pins
  output logic      ovf,
  output logic      pin
);
  initial
  begin
    ovf = 1'b0;
    pin = 1'b0;
  end
  always @(posedge clk)
  begin
    ovf <= tick;
    if (flip)
      pin <= ~pin;
  end
endmodule // cifl_src

// ===== testbench/cifl_core_irq_chk.sv
// Port assertions of the core interrupt flag block
`timescale 1ns/1ps
module cifl_core_irq_chk (
  // Clock and bus
  input wire        clk, rst, ce, psel, penable, pwrite, pready, pslverr,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  // Events and requests
  input wire        timer_zero_overflow, core_irq_req, irq,
  input wire [7:0]  periph_irq_pending
);
  logic [7:3] en_q;
  wire        wr0 = psel & penable & pwrite & ce & (paddr == 12'h000);
  always @(posedge clk)
    if (rst)
      en_q <= 5'h00;
    else if (wr0)
      en_q <= pwdata[7:3];
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_RST: assert property ($fell(rst) |-> !core_irq_req && !irq)
    else $error("request after reset");
  AST_GIE: assert property (!en_q[7] |-> !core_irq_req)
    else $error("request without global enable");
  AST_MASK: assert property (en_q == 5'h10 |-> !core_irq_req)
    else $error("masked source requested");
  AST_TMR: assert property (timer_zero_overflow && ce && !wr0 && en_q[7] && en_q[5]
    |=> core_irq_req) else $error("overflow not requested");
  AST_HOLD: assert property (core_irq_req && !wr0 && !en_q[6] |=> core_irq_req)
    else $error("flag dropped by itself");
  AST_PERI: assert property ((en_q[7] && en_q[6] && |periph_irq_pending) [*2]
    |-> core_irq_req) else $error("group request lost");
  AST_RDY: assert property (psel && penable |-> pready)
    else $error("slave stalled");
  AST_ERR: assert property (psel && penable && paddr > 12'h010 |-> pslverr)
    else $error("unmapped access accepted");
endmodule // cifl_core_irq_chk
bind cifl_core_irq cifl_core_irq_chk chk (.*);

// ===== testbench/tb_top.sv
// Testbench of the core interrupt flag block
`timescale 1ns/1ps
module tb_top;
  logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic        tick = 0, flip = 0, ovf, pin, pready, pslverr, req, irq, se, edg = 1;
  logic [3:0]  pb = 0;
  logic [7:0]  pp = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r, s = 32'h028D;
  int          err_total = 0, check_count = 0, cyc = 0;
  always #4 clk = ~clk;
  cifl_src src (.clk(clk), .tick(tick), .flip(flip), .ovf(ovf), .pin(pin));
  cifl_core_irq uut (.clk(clk), .rst(rst), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_zero_overflow(ovf), .external_interrupt_pin(pin),
    .ext_edge_rising(edg), .port_b_pins(pb), .periph_irq_pending(pp),
    .core_irq_req(req), .irq(irq));
  function logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  function logic rq(input logic [7:0] c, input logic [7:0] p);
    return c[7] & (|(c[5:3] & c[2:0]) | (c[6] & |p));
  endfunction
  task k(input logic [31:0] v, input logic [31:0] e);
    check_count++;
    if (v !== e)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, v, e);
    end
  endtask
  task a(input logic w, input logic [11:0] ad, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    r = prdata;
    se = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_total++;
      end_of_test;
    end
  end
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 0;
    a(0, 12'h000, 0);
    k(r, 0);
    a(0, 12'h020, 0);
    k(se, 1);
    $display("end reset");
    tick <= 1;
    @(posedge clk);
    tick <= 0;
    repeat (3) @(posedge clk);
    a(0, 0, 0);
    k(r, 32'h04);
    a(1, 0, 32'hA0);
    k(req, 0);
    tick <= 1;
    @(posedge clk);
    tick <= 0;
    repeat (3) @(posedge clk);
    k(req, rq(8'hA4, pp));
    a(1, 0, 0);
    $display("end timer");
    flip <= 1;
    @(posedge clk);
    flip <= 0;
    repeat (6) @(posedge clk);
    a(0, 0, 0);
    k(r, 32'h02);
    a(1, 0, 32'h92);
    k(req, 1);
    a(1, 0, 32'h82);
    k(req, 0);
    a(1, 0, 0);
    flip <= 1;
    @(posedge clk);
    flip <= 0;
    repeat (6) @(posedge clk);
    a(0, 0, 0);
    k(r, 0);
    edg <= 0;
    flip <= 1;
    @(posedge clk);
    flip <= 0;
    repeat (6) @(posedge clk);
    a(0, 0, 0);
    k(r, 0);
    flip <= 1;
    @(posedge clk);
    flip <= 0;
    repeat (6) @(posedge clk);
    a(0, 0, 0);
    k(r, 32'h02);
    a(1, 0, 0);
    edg <= 1;
    $display("end pin");
    s = xs(s);
    pb <= s[3:0] | 4'h1;
    repeat (5) @(posedge clk);
    a(1, 0, 0);
    a(0, 0, 0);
    k(r, 1);
    a(0, 12'h008, 0);
    k(r, {28'h0, pb});
    a(1, 0, 32'h88);
    k(req, 0);
    pb <= ~pb;
    repeat (5) @(posedge clk);
    k(req, 1);
    a(0, 12'h008, 0);
    a(1, 0, 0);
    $display("end port");
    s = xs(s);
    pp <= s[7:0] | 8'h01;
    a(1, 0, 32'h80);
    k(req, 0);
    a(1, 0, 32'hC0);
    k(req, rq(8'hC0, pp));
    pp <= 0;
    a(1, 0, 0);
    k(irq, 0);
    a(1, 12'h010, 7);
    k(irq, 1);
    a(1, 12'h00C, 7);
    k(irq, 0);
    $display("end group");
    end_of_test;
  end
endmodule // tb_top
